// File: lfsw_pkg.sv
package lfsw_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int FREQ_W     = 32;   // Frequency word, 1 Hz per LSB
    localparam int LOG_W      = 16;   // Log step fraction width
    localparam int LOG_FRAC   = 16;   // Log step is Q0.16 of present freq
    localparam int DWELL_W    = 16;   // Dwell entry width, microseconds

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ          = 20_000_000;
    localparam int CYC_PER_US      = CLK_HZ / 1_000_000;
    localparam int SETTLE_TIME_NS  = 1000;
    // Least time, so round up
    localparam int SETTLE_CYC_INT  = (SETTLE_TIME_NS * CYC_PER_US + 999) / 1000;
    localparam logic [7:0]  SETTLE_CYC   = 8'(SETTLE_CYC_INT);
    localparam logic [31:0] DWELL_SCALE  = 32'(CYC_PER_US);

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [FREQ_W-1:0]  FREQ_RST  = 32'h0000_0000;
    localparam logic [31:0]        DWELL_RST = 32'h0000_0000;
    localparam logic [7:0]         SETTLE_RST = 8'h00;

    // ------------------------------------------------------------------
    // Modes, shapes, spacing, states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_AUTO                 = 3'b000,
        MODE_SINGLE               = 3'b001,
        MODE_STEP                 = 3'b010,
        MODE_EXT_SINGLE           = 3'b011,
        MODE_EXT_STEP             = 3'b100,
        MODE_EXT_TOGGLED_RUN_CODE = 3'b101
    } lfsw_mode_t;

    typedef enum logic {
        SHAPE_SAWTOOTH = 1'b0,
        SHAPE_TRIANGLE = 1'b1
    } lfsw_shape_t;

    typedef enum logic {
        SPACING_LIN = 1'b0,
        SPACING_LOG = 1'b1
    } lfsw_spacing_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01,
        ST_HOLD = 2'b10
    } lfsw_state_t;

    // Sweep range and stepping configuration
    typedef struct packed {
        logic [FREQ_W-1:0]  start_freq;
        logic [FREQ_W-1:0]  stop_freq;
        logic [FREQ_W-1:0]  step_lin;
        logic [LOG_W-1:0]   step_log;
        logic [DWELL_W-1:0] dwell_us;
    } lfsw_cfg_t;

endpackage

// File: lfsw_edge.sv
`timescale 1ns/10ps
// Trigger synchroniser with selectable active edge
module lfsw_edge (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic trig_i,
    input  wire logic pol_falling_i,
    output logic      event_o
);

    logic meta_q;
    logic sync_q;
    logic last_q;

    // ------------------------------------------------------------------
    // Two-stage synchroniser, then history for edge detect
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= trig_i;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    // One pulse per qualifying edge; polarity picks rising or falling
    always_comb begin
        if (pol_falling_i) begin
            event_o = last_q & ~sync_q;
        end else begin
            event_o = sync_q & ~last_q;
        end
    end

endmodule // lfsw_edge

// File: lfsw_top.sv
`timescale 1ns/10ps
// Notes on behaviour
// - First trigger in toggled mode starts sweep
// - Second trigger halts, holds reached frequency
// - Third trigger restarts from start frequency
// - Toggled mode repeats cycles until stopped
// - Entering toggled mode stops, waits for trigger
// - Reset request loads start frequency
// - Execute request honoured only in single mode
// - Sawtooth: up, restart at start
// - Triangle: up to stop, then back down
// - Configured step width used in all modes
// - Spacing selects linear or logarithmic step
// - Linear: add fixed hertz increment
// - Log: add fraction of present frequency
// - Hold each step for dwell time in timed modes; step modes wait for a request
// - Dwell spans settling; settled part shorter
// - Trigger polarity selects active edge
// - Manual frequency write advances one step in step mode
module lfsw_top (
    input  wire logic                    CLK_I,
    input  wire logic                    SYS_RST_I,
    input  wire logic                    SWEEP_EN_I,
    input  wire lfsw_pkg::lfsw_mode_t    MODE_I,
    input  wire lfsw_pkg::lfsw_shape_t   SHAPE_I,
    input  wire lfsw_pkg::lfsw_spacing_t SPACING_I,
    input  wire lfsw_pkg::lfsw_cfg_t     CFG_I,
    input  wire logic                    TRIG_POL_FALLING_I,
    input  wire logic                    INSTRUMENT_TRIGGER_INPUT_I,
    input  wire logic                    EXEC_SINGLE_I,
    input  wire logic                    RESET_SWEEP_I,
    input  wire logic                    MAN_FREQ_WR_I,
    output logic [lfsw_pkg::FREQ_W-1:0]  FREQ_O,
    output logic                         RUNNING_O,
    output logic                         SETTLING_O,
    output logic                         STEP_STROBE_O
);
    import lfsw_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    // Sequencer registers
    lfsw_state_t        state_q;
    lfsw_mode_t         mode_q;
    logic               mode_valid_q;
    logic [FREQ_W-1:0]  freq_q;
    logic               dir_down_q;
    logic               wrap_q;
    logic [31:0]        dwell_cnt_q;
    logic [7:0]         settle_q;
    logic               running_q;
    logic               settling_q;
    logic               strobe_q;

    // Decoded requests
    logic               trig_ev;
    logic               mode_chg;
    logic               timed_mode;
    logic               repeat_mode;
    logic               step_mode;
    logic               step_ev;
    logic               dwell_done;
    logic               do_step;
    logic               start_ev;
    logic               hold_ev;
    logic               kick;

    logic [31:0]        dwell_cyc;
    logic [47:0]        log_prod;
    logic [FREQ_W-1:0]  delta_log;
    logic [FREQ_W-1:0]  delta;
    logic [FREQ_W:0]    up_sum;
    logic [FREQ_W:0]    down_floor;
    logic               hit_stop;
    logic               hit_start;

    // ------------------------------------------------------------------
    // Trigger input conditioning
    // ------------------------------------------------------------------
    // Event trails pin by two clocks
    lfsw_edge u_edge (
        .clk_i         (CLK_I),
        .rst_i         (SYS_RST_I),
        .trig_i        (INSTRUMENT_TRIGGER_INPUT_I),
        .pol_falling_i (TRIG_POL_FALLING_I),
        .event_o       (trig_ev)
    );

    // ------------------------------------------------------------------
    // Mode classification
    // ------------------------------------------------------------------
    // First cycle after reset counts as a change so entry actions run
    assign mode_chg = ~mode_valid_q | (MODE_I != mode_q);

    // Timed, repeating or stepped
    always_comb begin
        timed_mode  = 1'b0;
        repeat_mode = 1'b0;
        step_mode   = 1'b0;
        step_ev     = 1'b0;
        case (MODE_I)
            MODE_AUTO: begin
                timed_mode  = 1'b1;
                repeat_mode = 1'b1;
            end
            MODE_SINGLE: begin
                timed_mode = 1'b1;
            end
            MODE_STEP: begin
                step_mode = 1'b1;
                step_ev   = MAN_FREQ_WR_I;
            end
            MODE_EXT_SINGLE: begin
                timed_mode = 1'b1;
            end
            MODE_EXT_STEP: begin
                step_mode = 1'b1;
                step_ev   = trig_ev;
            end
            MODE_EXT_TOGGLED_RUN_CODE: begin
                timed_mode  = 1'b1;
                repeat_mode = 1'b1;
            end
            default: begin
                // Unused codes never step
                timed_mode = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Sweep start and halt events
    // ------------------------------------------------------------------
    // Dropped in a mode-change cycle
    always_comb begin
        start_ev = 1'b0;
        hold_ev  = 1'b0;
        if (SWEEP_EN_I && !mode_chg) begin
            case (MODE_I)
                MODE_SINGLE: begin
                    // Execute is ignored in every other mode
                    start_ev = EXEC_SINGLE_I && (state_q != ST_RUN);
                end
                MODE_EXT_SINGLE: begin
                    start_ev = trig_ev && (state_q != ST_RUN);
                end
                MODE_EXT_TOGGLED_RUN_CODE: begin
                    start_ev = trig_ev && (state_q != ST_RUN);
                    hold_ev  = trig_ev && (state_q == ST_RUN);
                end
                default: begin
                    start_ev = 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Step width and leg limits
    // ------------------------------------------------------------------
    // Floored Q0.16 share of freq
    assign log_prod  = 48'(freq_q) * 48'(CFG_I.step_log);
    assign delta_log = log_prod[FREQ_W+LOG_FRAC-1:LOG_FRAC];

    // A zero increment would park the sweep forever, so force one LSB
    always_comb begin
        if (SPACING_I == SPACING_LOG) begin
            delta = (delta_log == '0) ? FREQ_W'(1) : delta_log;
        end else begin
            delta = (CFG_I.step_lin == '0) ? FREQ_W'(1) : CFG_I.step_lin;
        end
    end

    // Extra bit: no wrap in compares
    assign up_sum     = {1'b0, freq_q} + {1'b0, delta};
    assign down_floor = {1'b0, CFG_I.start_freq} + {1'b0, delta};
    assign hit_stop   = up_sum >= {1'b0, CFG_I.stop_freq};
    assign hit_start  = {1'b0, freq_q} <= down_floor;

    // ------------------------------------------------------------------
    // Dwell timing
    // ------------------------------------------------------------------
    // Dwell is the whole step period; settling eats into it
    assign dwell_cyc  = 32'(CFG_I.dwell_us) * DWELL_SCALE;
    assign dwell_done = (dwell_cnt_q + 32'h0000_0001) >= dwell_cyc;

    // Dwell or request paces steps
    assign do_step = SWEEP_EN_I && !mode_chg && (state_q == ST_RUN) &&
                     (timed_mode ? dwell_done : (step_mode & step_ev));

    // Any load restarts timers
    assign kick    = do_step | start_ev | RESET_SWEEP_I | mode_chg;

    // ------------------------------------------------------------------
    // Mode history
    // ------------------------------------------------------------------
    // Last mode, to spot a change
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            mode_q       <= MODE_AUTO;
            mode_valid_q <= 1'b0;
        end else begin
            mode_q       <= MODE_I;
            mode_valid_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Sequencer state, frequency and direction
    // ------------------------------------------------------------------
    // Priority: off, mode, reset, halt, start, step
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            state_q    <= ST_IDLE;
            freq_q     <= FREQ_RST;
            dir_down_q <= 1'b0;
            wrap_q     <= 1'b0;
        end else if (!SWEEP_EN_I) begin
            // Sweep off: stop, keep the frequency where it is
            state_q <= ST_IDLE;
        end else if (mode_chg) begin
            case (MODE_I)
                MODE_AUTO: begin
                    // Continue from the present setting
                    state_q <= ST_RUN;
                end
                MODE_STEP: begin
                    // From present word
                    state_q <= ST_RUN;
                end
                MODE_EXT_STEP: begin
                    // From start frequency
                    state_q    <= ST_RUN;
                    freq_q     <= CFG_I.start_freq;
                    dir_down_q <= 1'b0;
                    wrap_q     <= 1'b0;
                end
                default: begin
                    // Stop; start frequency loaded on the next start
                    state_q <= ST_IDLE;
                end
            endcase
        end else if (RESET_SWEEP_I) begin
            // Run state kept
            freq_q     <= CFG_I.start_freq;
            dir_down_q <= 1'b0;
            wrap_q     <= 1'b0;
        end else if (hold_ev) begin
            // Frozen in place
            state_q <= ST_HOLD;
        end else if (start_ev) begin
            state_q    <= ST_RUN;
            freq_q     <= CFG_I.start_freq;
            dir_down_q <= 1'b0;
            wrap_q     <= 1'b0;
        end else if (do_step) begin
            if (wrap_q) begin
                // Sawtooth flyback after the stop frequency was shown
                freq_q <= CFG_I.start_freq;
                wrap_q <= 1'b0;
            end else if (!dir_down_q) begin
                if (hit_stop) begin
                    freq_q <= CFG_I.stop_freq;
                    if (SHAPE_I == SHAPE_TRIANGLE) begin
                        // Turn at stop
                        dir_down_q <= 1'b1;
                    end else if (repeat_mode || step_mode) begin
                        wrap_q <= 1'b1;
                    end else begin
                        // One-shot ends at stop
                        state_q <= ST_IDLE;
                    end
                end else begin
                    freq_q <= up_sum[FREQ_W-1:0];
                end
            end else begin
                if (hit_start) begin
                    freq_q     <= CFG_I.start_freq;
                    dir_down_q <= 1'b0;
                    // One-shot ends at start
                    if (!(repeat_mode || step_mode)) begin
                        state_q <= ST_IDLE;
                    end
                end else begin
                    freq_q <= freq_q - delta;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Dwell counter
    // ------------------------------------------------------------------
    // Restarts on every frequency change so each step gets a full dwell
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            dwell_cnt_q <= DWELL_RST;
        end else if (kick || (state_q != ST_RUN)) begin
            dwell_cnt_q <= DWELL_RST;
        end else begin
            dwell_cnt_q <= dwell_cnt_q + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------------
    // Settling window inside each step
    // ------------------------------------------------------------------
    // Zero means settled
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            settle_q <= SETTLE_RST;
        end else if (kick) begin
            settle_q <= SETTLE_CYC;
        end else if (settle_q != SETTLE_RST) begin
            settle_q <= settle_q - 8'h01;
        end
    end

    // ------------------------------------------------------------------
    // Registered status outputs
    // ------------------------------------------------------------------
    // Status trails the sequencer state by one cycle
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            running_q  <= 1'b0;
            settling_q <= 1'b0;
            strobe_q   <= 1'b0;
        end else begin
            running_q  <= (state_q == ST_RUN);
            settling_q <= (settle_q != SETTLE_RST);
            strobe_q   <= do_step;
        end
    end

    // Straight from flops
    assign FREQ_O        = freq_q;
    assign RUNNING_O     = running_q;
    assign SETTLING_O    = settling_q;
    assign STEP_STROBE_O = strobe_q;

endmodule // lfsw_top

// File: lfsw_trig_src.sv
`timescale 1ns/10ps
// ----
// Far-side trigger source: 4-cycle pulse per request
// ----
module lfsw_trig_src (
    input  wire logic clk_i,
    input  wire logic fire_i,
    input  wire logic falling_i,
    output logic      trig_o
);
    logic [2:0] cnt_q = 3'h0;

    // Pulse length counter, no reset so the line is never unknown
    always_ff @(posedge clk_i) begin
        if (fire_i) begin
            cnt_q <= 3'h4;
        end else if (cnt_q != 3'h0) begin
            cnt_q <= cnt_q - 3'h1;
        end
    end

    // Idle level is the inactive one, so only the pulse front is an active edge
    assign trig_o = falling_i ^ (cnt_q != 3'h0);
endmodule // lfsw_trig_src

// File: lfsw_top_assertions.sv
`timescale 1ns/10ps
module lfsw_top_assertions (
    input wire logic                    CLK_I,
    input wire logic                    SYS_RST_I,
    input wire logic                    SWEEP_EN_I,
    input wire lfsw_pkg::lfsw_mode_t    MODE_I,
    input wire lfsw_pkg::lfsw_shape_t   SHAPE_I,
    input wire lfsw_pkg::lfsw_spacing_t SPACING_I,
    input wire lfsw_pkg::lfsw_cfg_t     CFG_I,
    input wire logic                    TRIG_POL_FALLING_I,
    input wire logic                    INSTRUMENT_TRIGGER_INPUT_I,
    input wire logic                    EXEC_SINGLE_I,
    input wire logic                    RESET_SWEEP_I,
    input wire logic                    MAN_FREQ_WR_I,
    input wire logic [31:0]             FREQ_O,
    input wire logic                    RUNNING_O,
    input wire logic                    SETTLING_O,
    input wire logic                    STEP_STROBE_O
);
    import lfsw_pkg::*;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);
    // ----
    // Helpers
    // ----
    logic        live_q;
    lfsw_mode_t  mode_q;
    logic [31:0] gap_q;
    logic        prev_auto_q;
    logic        quiet;

    // Mode history; first edge after reset is a forced mode entry
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            live_q <= 1'b0;
            mode_q <= MODE_AUTO;
        end else begin
            live_q <= 1'b1;
            mode_q <= MODE_I;
        end
    end

    // Cycles between strobes; a reset request may restart the timer, so forget
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            gap_q       <= 32'h0;
            prev_auto_q <= 1'b0;
        end else if (STEP_STROBE_O) begin
            gap_q       <= 32'h1;
            prev_auto_q <= (MODE_I == MODE_AUTO) && quiet;
        end else begin
            gap_q       <= gap_q + 32'h1;
            prev_auto_q <= prev_auto_q && quiet;
        end
    end

    // No higher-priority request in this cycle
    assign quiet = live_q && SWEEP_EN_I && (MODE_I == mode_q) && !RESET_SWEEP_I;

    sequence s_act;
        TRIG_POL_FALLING_I ? $fell(INSTRUMENT_TRIGGER_INPUT_I) : $rose(INSTRUMENT_TRIGGER_INPUT_I);
    endsequence
    sequence s_started;
        (FREQ_O == CFG_I.start_freq) ##[1:2] RUNNING_O;
    endsequence
    sequence s_halted;
        !RUNNING_O ##1 $stable(FREQ_O)[*4];
    endsequence

    property p_reset_load;
        RESET_SWEEP_I && live_q && SWEEP_EN_I && MODE_I == mode_q |=> FREQ_O == CFG_I.start_freq;
    endproperty
    property p_exec_go;
        EXEC_SINGLE_I && MODE_I == MODE_SINGLE && !RUNNING_O && quiet |=> FREQ_O == CFG_I.start_freq;
    endproperty
    property p_exec_refused;
        EXEC_SINGLE_I && MODE_I inside {MODE_EXT_SINGLE, MODE_EXT_TOGGLED_RUN_CODE} && !RUNNING_O && quiet
            |=> $stable(FREQ_O) ##1 !RUNNING_O;
    endproperty
    property p_clamp;
        STEP_STROBE_O && CFG_I.start_freq <= CFG_I.stop_freq |-> FREQ_O <= CFG_I.stop_freq;
    endproperty
    property p_settle;
        live_q && $changed(FREQ_O) |-> ##[0:1] SETTLING_O;
    endproperty
    property p_dwell;
        STEP_STROBE_O && prev_auto_q && MODE_I == MODE_AUTO && CFG_I.dwell_us != 16'h0
            |-> gap_q == 32'(CFG_I.dwell_us) * DWELL_SCALE;
    endproperty
    property p_trig_run;
        (MODE_I == MODE_EXT_TOGGLED_RUN_CODE && SWEEP_EN_I && live_q && !RUNNING_O) ##0 s_act |-> ##[2:5] s_started;
    endproperty
    property p_trig_halt;
        (MODE_I == MODE_EXT_TOGGLED_RUN_CODE && SWEEP_EN_I && live_q && RUNNING_O) ##0 s_act |-> ##[4:7] s_halted;
    endproperty
    property p_man_step;
        MAN_FREQ_WR_I && MODE_I == MODE_STEP && RUNNING_O && quiet |=> $changed(FREQ_O) ##[0:1] STEP_STROBE_O;
    endproperty
    property p_man_quiet;
        MODE_I == MODE_STEP && !MAN_FREQ_WR_I && quiet |=> $stable(FREQ_O);
    endproperty

    a_reset_load:   assert property (p_reset_load)   else $error("reset request did not load start");
    a_exec_go:      assert property (p_exec_go)      else $error("execute did not start sweep");
    a_exec_refused: assert property (p_exec_refused) else $error("execute acted outside single");
    a_clamp:        assert property (p_clamp)        else $error("frequency beyond stop");
    a_settle:       assert property (p_settle)       else $error("no settle window after load");
    a_dwell:        assert property (p_dwell)        else $error("step period differs from dwell");
    a_trig_run:     assert property (p_trig_run)     else $error("trigger did not start at start");
    a_trig_halt:    assert property (p_trig_halt)    else $error("trigger did not halt sweep");
    a_man_step:     assert property (p_man_step)     else $error("manual write did not step");
    a_man_quiet:    assert property (p_man_quiet)    else $error("step mode moved unasked");
endmodule // lfsw_top_assertions

// File: lfsw_top_tb.sv
`timescale 1ns/10ps
module lfsw_top_tb;
    import lfsw_pkg::*;
    logic          clk     = 1'b0;
    logic          rst     = 1'b1;
    logic          en      = 1'b0;
    lfsw_mode_t    mode    = MODE_SINGLE;
    lfsw_shape_t   shape   = SHAPE_SAWTOOTH;
    lfsw_spacing_t spc     = SPACING_LIN;
    lfsw_cfg_t     cfg     = '{32'h0000_03E8, 32'h0000_03FC, 32'h0000_0007, 16'h0400, 16'h0001};
    logic          pol     = 1'b0;
    logic          fire    = 1'b0;
    logic          exec    = 1'b0;
    logic          rsw     = 1'b0;
    logic          man     = 1'b0;
    logic          trig;
    logic [31:0]   freq;
    logic          running;
    logic          settling;
    logic          strobe;
    logic [31:0]   f;
    int            miscompares = 0;
    int            samples_checked = 0;

    // Clock, 50 ns period
    always #25 clk = ~clk;

    lfsw_top uut (.CLK_I(clk), .SYS_RST_I(rst), .SWEEP_EN_I(en), .MODE_I(mode), .SHAPE_I(shape),
        .SPACING_I(spc), .CFG_I(cfg), .TRIG_POL_FALLING_I(pol), .INSTRUMENT_TRIGGER_INPUT_I(trig),
        .EXEC_SINGLE_I(exec), .RESET_SWEEP_I(rsw), .MAN_FREQ_WR_I(man), .FREQ_O(freq),
        .RUNNING_O(running), .SETTLING_O(settling), .STEP_STROBE_O(strobe));
    lfsw_trig_src u_src (.clk_i(clk), .fire_i(fire), .falling_i(pol), .trig_o(trig));

    // ----
    // Helpers
    // ----
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // Outputs are sampled at the falling edge, well clear of updates
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Bounded wait for the step strobe; a lost strobe counts once
    task automatic wstep();
        int i;
        for (i = 0; i < 400; i++) begin
            @(negedge clk);
            if (strobe === 1'b1) break;
        end
        chk("strobe", 32'(i < 400), 32'h1);
    endtask
    // One-cycle request: 0 execute, 1 reset sweep, 2 manual write, 3 trigger
    task automatic kick(input int w);
        @(posedge clk);
        case (w)
            0: exec <= 1'b1;
            1: rsw <= 1'b1;
            2: man <= 1'b1;
            default: fire <= 1'b1;
        endcase
        @(posedge clk);
        exec <= 1'b0;
        rsw  <= 1'b0;
        man  <= 1'b0;
        fire <= 1'b0;
    endtask
    task automatic set_mode(input lfsw_mode_t m);
        @(posedge clk);
        mode <= m;
        cyc(3);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // ----
    // Scenarios
    // ----
    task automatic t_auto_saw();
        logic [31:0] exp_saw [5] = '{32'h3EF, 32'h3F6, 32'h3FC, 32'h3E8, 32'h3EF};
        kick(1);
        cyc(2);
        chk("freq", freq, cfg.start_freq);
        set_mode(MODE_AUTO);
        // Lin 7 Hz from 1000: clamp at 1020, then wrap to start and keep going
        foreach (exp_saw[i]) begin
            wstep();
            chk("freq", freq, exp_saw[i]);
        end
    endtask
    task automatic t_tri_log();
        logic [31:0] exp_tri [5] = '{32'h3F7, 32'h3FC, 32'h3ED, 32'h3E8, 32'h3F7};
        @(posedge clk);
        shape <= SHAPE_TRIANGLE;
        spc   <= SPACING_LOG;
        kick(1);
        cyc(2);
        chk("freq", freq, cfg.start_freq);
        // 1/64 of present freq: up to stop, back down, then up again
        foreach (exp_tri[i]) begin
            wstep();
            chk("freq", freq, exp_tri[i]);
        end
    endtask
    task automatic t_toggle();
        set_mode(MODE_EXT_TOGGLED_RUN_CODE);
        f = freq;
        cyc(30);
        chk("running", running, 1'b0);
        chk("freq", freq, f);
        kick(3);
        cyc(8);
        chk("freq", freq, cfg.start_freq);
        chk("settling", settling, 1'b1);
        chk("running", running, 1'b1);
        repeat (5) wstep();
        chk("freq", freq, 32'h3F7);
        kick(3);
        cyc(8);
        f = freq;
        chk("running", running, 1'b0);
        cyc(40);
        chk("freq", freq, f);
        chk("settling", settling, 1'b0);
        // Polarity flip makes the line rise, which is now the inactive edge
        @(posedge clk);
        pol <= 1'b1;
        cyc(12);
        chk("running", running, 1'b0);
        kick(3);
        cyc(8);
        chk("freq", freq, cfg.start_freq);
        chk("running", running, 1'b1);
        kick(3);
        cyc(8);
        chk("running", running, 1'b0);
    endtask
    task automatic t_exec();
        int i;
        set_mode(MODE_EXT_SINGLE);
        f = freq;
        kick(0);
        cyc(4);
        chk("running", running, 1'b0);
        chk("freq", freq, f);
        @(posedge clk);
        shape <= SHAPE_SAWTOOTH;
        spc   <= SPACING_LIN;
        set_mode(MODE_SINGLE);
        kick(0);
        cyc(3);
        chk("freq", freq, cfg.start_freq);
        chk("running", running, 1'b1);
        for (i = 0; i < 300 && running !== 1'b0; i++) cyc(1);
        chk("freq", freq, cfg.stop_freq);
    endtask
    task automatic t_step();
        set_mode(MODE_STEP);
        kick(1);
        cyc(2);
        chk("freq", freq, cfg.start_freq);
        cyc(30);
        chk("freq", freq, cfg.start_freq);
        kick(2);
        cyc(2);
        chk("freq", freq, 32'h3EF);
        set_mode(MODE_EXT_STEP);
        chk("freq", freq, cfg.start_freq);
    endtask

    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        en  <= 1'b1;
        cyc(3);
        t_auto_saw();
        t_tri_log();
        t_toggle();
        t_exec();
        t_step();
        end_of_test();
    end

    // Watchdog, some thirty times the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        end_of_test();
    end
endmodule // lfsw_top_tb

bind lfsw_top lfsw_top_assertions u_chk (.CLK_I, .SYS_RST_I, .SWEEP_EN_I, .MODE_I, .SHAPE_I, .SPACING_I,
    .CFG_I, .TRIG_POL_FALLING_I, .INSTRUMENT_TRIGGER_INPUT_I, .EXEC_SINGLE_I, .RESET_SWEEP_I,
    .MAN_FREQ_WR_I, .FREQ_O, .RUNNING_O, .SETTLING_O, .STEP_STROBE_O);
